/* File: src/ssi_pkg.sv */
// Constants, field layouts and types of the strap sampling block
package ssi_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

  // Control fields
  localparam int unsigned CTRL_CONFIGURED = 0;
  localparam int unsigned CTRL_SUSPENDED = 1;
  localparam int unsigned CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  // Status fields
  localparam int unsigned ST_FPC_LSB = 0;
  localparam int unsigned ST_CFG_LSB = 2;
  localparam int unsigned ST_CHG_LSB = 4;
  localparam int unsigned ST_COMPOUND = 8;
  localparam int unsigned ST_SELF_PWR = 9;
  localparam int unsigned ST_STRAP_EN = 10;
  localparam int unsigned ST_CAPTURED = 11;
  localparam int unsigned ST_ACTIVE = 12;

  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Straps and codes
  // ****************************************************************
  localparam int unsigned NUM_PORTS = 4;

  localparam logic [1:0] CFG_DEFAULT = 2'h0;
  localparam logic [1:0] CFG_SERIAL_MGMT = 2'h1;
  localparam logic [1:0] CFG_BUS_POWERED = 2'h2;
  localparam logic [1:0] CFG_EEPROM = 2'h3;

  localparam logic [1:0] FPC_NONE = 2'h0;
  localparam logic [1:0] FPC_PORT1 = 2'h1;
  localparam logic [1:0] FPC_PORT12 = 2'h2;
  localparam logic [1:0] FPC_PORT123 = 2'h3;

  // Codes with this bit set drive the indicator active low
  localparam int unsigned FPC_POLARITY_BIT = 0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    SSI_WAIT1 = 4'b0001,
    SSI_WAIT2 = 4'b0010,
    SSI_CAPTURE = 4'b0100,
    SSI_RUN = 4'b1000
  } ssi_phase_t;

  typedef struct packed {
    logic [1:0] cfg_sel;
    logic fixed_port_strap1;
    logic fixed_port_strap0;
    logic [NUM_PORTS-1:0] charge_enable_straps;
    logic self_power_detect;
  } ssi_pins_t;

  typedef struct packed {
    logic [1:0] cfg_sel;
    logic strap_en;
    logic [1:0] fixed_port_code;
    logic [NUM_PORTS-1:0] charge_enable;
  } ssi_strap_t;

  typedef struct packed {
    ssi_phase_t phase;
    ssi_pins_t sync1;
    ssi_pins_t sync2;
    ssi_strap_t strap;
    logic [CTRL_W-1:0] ctrl;
    logic self_powered;
    logic compound;
    logic ind_o;
    logic ind_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssi_state_t;

  localparam ssi_state_t STATE_RESET = '{
    phase: SSI_WAIT1,
    sync1: '0,
    sync2: '0,
    strap: '0,
    ctrl: CTRL_RESET,
    self_powered: 1'b0,
    compound: 1'b0,
    ind_o: 1'b0,
    ind_oe: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: RDATA_ZERO
  };

endpackage : ssi_pkg

/* File: src/ssi_strap_sampler.sv */
// Strap capture, indicator drive and APB register slave
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps

module ssi_strap_sampler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] cfg_sel,
  input wire logic fixed_port_strap0_i,
  output logic activity_indicator_o,
  output logic activity_indicator_oe,
  input wire logic fixed_port_strap1,
  input wire logic [ssi_pkg::NUM_PORTS-1:0] charge_enable_straps,
  input wire logic self_power_detect,
  output logic [1:0] fixed_port_code,
  output logic [ssi_pkg::NUM_PORTS-1:0] charge_enable,
  output logic compound_device,
  output logic self_powered,
  output logic strap_captured
);

  // ****************************************************************
  // State
  // ****************************************************************
  ssi_pkg::ssi_state_t state_q;
  ssi_pkg::ssi_state_t state_d;
  ssi_pkg::ssi_pins_t pins_raw;
  logic strap_en;
  logic hub_active;
  logic [31:0] status_word;

  assign pins_raw.cfg_sel = cfg_sel;
  assign pins_raw.fixed_port_strap1 = fixed_port_strap1;
  assign pins_raw.fixed_port_strap0 = fixed_port_strap0_i;
  assign pins_raw.charge_enable_straps = charge_enable_straps;
  assign pins_raw.self_power_detect = self_power_detect;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    strap_en = 1'b0;

    // Pins are asynchronous; two stages before any use
    state_d.sync1 = pins_raw;
    state_d.sync2 = state_q.sync1;

    // Hub state as set by software
    hub_active = state_q.ctrl[ssi_pkg::CTRL_CONFIGURED] &
                 !state_q.ctrl[ssi_pkg::CTRL_SUSPENDED];

    // Capture waits for the synchroniser to fill after release
    unique case (state_q.phase)
      ssi_pkg::SSI_WAIT1: begin
        state_d.phase = ssi_pkg::SSI_WAIT2;
      end
      ssi_pkg::SSI_WAIT2: begin
        state_d.phase = ssi_pkg::SSI_CAPTURE;
      end
      ssi_pkg::SSI_CAPTURE: begin
        state_d.strap.cfg_sel = state_q.sync2.cfg_sel;
        strap_en = (state_q.sync2.cfg_sel == ssi_pkg::CFG_DEFAULT) ||
                   (state_q.sync2.cfg_sel ==
                    ssi_pkg::CFG_BUS_POWERED);
        state_d.strap.strap_en = strap_en;
        if (strap_en) begin
          // Unpulled pin reads low through the internal pull-down
          state_d.strap.fixed_port_code = {
            state_q.sync2.fixed_port_strap1,
            state_q.sync2.fixed_port_strap0
          };
          state_d.strap.charge_enable =
            state_q.sync2.charge_enable_straps;
        end else begin
          state_d.strap.fixed_port_code = ssi_pkg::FPC_NONE;
          state_d.strap.charge_enable = '0;
        end
        state_d.phase = ssi_pkg::SSI_RUN;
      end
      ssi_pkg::SSI_RUN: begin
        // Straps are left alone until the next reset
        state_d.phase = ssi_pkg::SSI_RUN;
      end
    endcase

    // Any fixed port makes a compound device
    state_d.compound =
      (state_d.strap.fixed_port_code != ssi_pkg::FPC_NONE);

    // Low means all power from upstream
    state_d.self_powered = state_q.sync2.self_power_detect;

    // Pin stays an input until the strap has been taken
    state_d.ind_oe = (state_q.phase == ssi_pkg::SSI_RUN);
    // Odd codes invert the indicator
    state_d.ind_o = hub_active ^
      state_q.strap.fixed_port_code[ssi_pkg::FPC_POLARITY_BIT];

    // ****************************************************************
    // APB slave
    // ****************************************************************
    status_word = ssi_pkg::RDATA_ZERO;
    status_word[ssi_pkg::ST_FPC_LSB +: 2] = state_q.strap.fixed_port_code;
    status_word[ssi_pkg::ST_CFG_LSB +: 2] = state_q.strap.cfg_sel;
    status_word[ssi_pkg::ST_CHG_LSB +: ssi_pkg::NUM_PORTS] =
      state_q.strap.charge_enable;
    status_word[ssi_pkg::ST_COMPOUND] = state_q.compound;
    status_word[ssi_pkg::ST_SELF_PWR] = state_q.self_powered;
    status_word[ssi_pkg::ST_STRAP_EN] = state_q.strap.strap_en;
    status_word[ssi_pkg::ST_CAPTURED] = state_q.ind_oe;
    status_word[ssi_pkg::ST_ACTIVE] = hub_active;

    state_d.pready = 1'b0;
    state_d.pslverr = 1'b0;

    // Answer is prepared in setup so read data is stable in access
    if (psel && !penable) begin
      state_d.pready = 1'b1;
      state_d.prdata = ssi_pkg::RDATA_ZERO;
      unique case (paddr)
        ssi_pkg::ADDR_CTRL: begin
          state_d.prdata[ssi_pkg::CTRL_W-1:0] = state_q.ctrl;
        end
        ssi_pkg::ADDR_STATUS: begin
          state_d.prdata = status_word;
        end
        default: begin
          state_d.pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable && state_q.pready) begin
      // Write lands at the completing edge only
      state_d.pslverr = 1'b0;
      if (pwrite && (paddr == ssi_pkg::ADDR_CTRL)) begin
        state_d.ctrl = pwdata[ssi_pkg::CTRL_W-1:0];
      end
    end else if (psel && penable) begin
      state_d.pready = state_q.pready;
      state_d.pslverr = state_q.pslverr;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ssi_pkg::STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = state_q.prdata;
  assign pready = state_q.pready;
  assign pslverr = state_q.pslverr;
  assign activity_indicator_o = state_q.ind_o;
  assign activity_indicator_oe = state_q.ind_oe;
  assign fixed_port_code = state_q.strap.fixed_port_code;
  assign charge_enable = state_q.strap.charge_enable;
  assign compound_device = state_q.compound;
  assign self_powered = state_q.self_powered;
  assign strap_captured = state_q.ind_oe;

endmodule : ssi_strap_sampler

/* File: dv/ssi_board_model.sv */
// Board side of the shared strap and indicator pin
`timescale 1ns/1ps
module ssi_board_model (
  input wire logic strap0,
  input wire logic ind_o,
  input wire logic ind_oe,
  output logic pin,
  output logic led_lit
);
  // ****
  // Pin
  // ****
  // Released pin rests at its pull level, low when unstrapped
  assign pin = ind_oe ? ind_o : strap0;
  // LED is wired for the sense its strap picks
  assign led_lit = pin ^ strap0;
endmodule : ssi_board_model

/* File: dv/ssi_checker.sv */
// Port assertions of the strap sampler
`timescale 1ns/1ps
module ssi_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] cfg_sel,
  input wire logic fixed_port_strap0_i,
  input wire logic activity_indicator_o,
  input wire logic activity_indicator_oe,
  input wire logic fixed_port_strap1,
  input wire logic [ssi_pkg::NUM_PORTS-1:0] charge_enable_straps,
  input wire logic self_power_detect,
  input wire logic [1:0] fixed_port_code,
  input wire logic [ssi_pkg::NUM_PORTS-1:0] charge_enable,
  input wire logic compound_device,
  input wire logic self_powered,
  input wire logic strap_captured
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe; strap_captured == activity_indicator_oe; endproperty
  a_oe: assert property (p_oe) else $error("oe wrong");
  property p_hold;
    strap_captured |=> $stable(fixed_port_code) && $stable(charge_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("straps moved");
  property p_cmp;
    strap_captured |-> compound_device == (fixed_port_code != 2'h0);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compound wrong");
  property p_pwr;
    strap_captured |-> self_powered == $past(self_power_detect, 3);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power wrong");
  property p_cap;
    $rose(strap_captured) && !cfg_sel[0] |->
      fixed_port_code == $past({fixed_port_strap1, fixed_port_strap0_i}, 2);
  endproperty
  a_cap: assert property (p_cap) else $error("code wrong");
  property p_off;
    $rose(strap_captured) && cfg_sel[0] |->
      fixed_port_code == 2'h0 && charge_enable == '0;
  endproperty
  a_off: assert property (p_off) else $error("straps used");
  property p_chg;
    $rose(strap_captured) && !cfg_sel[0] |->
      charge_enable == $past(charge_enable_straps, 2);
  endproperty
  a_chg: assert property (p_chg) else $error("charge wrong");
  property p_pol;
    $rose(activity_indicator_oe) |->
      activity_indicator_o == fixed_port_code[0];
  endproperty
  a_pol: assert property (p_pol) else $error("idle level");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready long");
  c_cmp: cover property (compound_device);
  c_off: cover property ($rose(strap_captured) && cfg_sel[0]);
  c_err: cover property (pslverr);
endmodule : ssi_checker
bind ssi_strap_sampler ssi_checker i_ssi_checker (.pclk, .presetn,
  .pready, .pslverr, .cfg_sel, .fixed_port_strap0_i, .activity_indicator_o,
  .activity_indicator_oe, .fixed_port_strap1, .charge_enable_straps,
  .self_power_detect, .fixed_port_code, .charge_enable, .compound_device,
  .self_powered, .strap_captured);

/* File: dv/ssi_strap_sampler_tb.sv */
// Self-checking bench of the strap sampler
`timescale 1ns/1ps
module ssi_strap_sampler_tb;
  // ****
  // Bench
  // ****
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, rerr, s0 = 1'b0;
  logic [1:0] cfg_sel = 2'h0, fixed_port_code;
  logic fixed_port_strap1 = 1'b0, self_power_detect = 1'b0;
  logic [3:0] charge_enable_straps = 4'h0, charge_enable;
  logic fixed_port_strap0_i, activity_indicator_o, activity_indicator_oe;
  logic compound_device, self_powered, strap_captured, led_lit;
  int errors = 0, comparisons = 0;
  always #50 pclk = ~pclk;
  ssi_strap_sampler i_ssi_strap_sampler (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfg_sel,
    .fixed_port_strap0_i, .activity_indicator_o, .activity_indicator_oe,
    .fixed_port_strap1, .charge_enable_straps, .self_power_detect,
    .fixed_port_code, .charge_enable, .compound_device, .self_powered,
    .strap_captured);
  ssi_board_model i_ssi_board_model (.strap0(s0),
    .ind_o(activity_indicator_o), .ind_oe(activity_indicator_oe),
    .pin(fixed_port_strap0_i), .led_lit);
  task automatic chk(input logic c, input string m);
    comparisons++;
    if (c !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // Waits on pready with a bound, then releases the request
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, "no pready");
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rst(input logic [1:0] c, k, input logic [3:0] g);
    presetn <= 1'b0;
    cfg_sel <= c;
    {fixed_port_strap1, s0} <= k;
    charge_enable_straps <= g;
    repeat (4) @(posedge pclk);
    chk(activity_indicator_oe === 1'b0, "oe in reset");
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : rst
  task automatic t_caps();
    logic [1:0] e;
    logic [3:0] g;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        g = {k[1:0], ~k[1:0]};
        rst(c[1:0], k[1:0], g);
        e = c[0] ? 2'h0 : k[1:0];
        chk(fixed_port_code === e, "code");
        chk(charge_enable === (c[0] ? 4'h0 : g), "charge");
        chk(compound_device === (e != 2'h0), "compound");
        chk(activity_indicator_oe === 1'b1, "oe");
        apb(1'b0, ssi_pkg::ADDR_STATUS, 32'h0000_0000);
        // Captured, strap enable and code fields; no power, hub idle
        chk(rd === {19'h0, 1'b0, 1'b1, ~c[0], 1'b0, (e != 2'h0),
          (c[0] ? 4'h0 : g), c[1:0], e}, "status");
      end
    end
  endtask : t_caps
  task automatic t_ind();
    logic act;
    for (int k = 0; k < 4; k++) begin
      rst(2'h0, k[1:0], 4'h0);
      for (int m = 0; m < 4; m++) begin
        apb(1'b1, ssi_pkg::ADDR_CTRL, 32'(m));
        repeat (2) @(posedge pclk);
        act = (m == 1);
        chk(led_lit === act, "led");
        chk(activity_indicator_o === (act ^ k[0]), "level");
        apb(1'b0, ssi_pkg::ADDR_CTRL, 32'h0000_0000);
        chk(rd === 32'(m), "ctrl readback");
      end
    end
  endtask : t_ind
  // Straps move after capture; the captured code must not
  task automatic t_hold();
    fixed_port_strap1 <= 1'b0;
    charge_enable_straps <= 4'hF;
    repeat (5) @(posedge pclk);
    chk(fixed_port_code === 2'h3, "held code");
    chk(charge_enable === 4'h0, "held charge");
  endtask : t_hold
  task automatic t_pwr();
    for (int p = 1; p >= 0; p--) begin
      self_power_detect <= p[0];
      repeat (5) @(posedge pclk);
      chk(self_powered === p[0], "power");
    end
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rerr === 1'b1 && rd === 32'h0000_0000, "unmapped");
  endtask : t_pwr
  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  initial begin
    #200_000;
    errors++;
    results();
  end
  initial begin
    @(posedge pclk);
    t_caps();
    t_ind();
    t_hold();
    t_pwr();
    results();
  end
endmodule : ssi_strap_sampler_tb
